// [ssf_host_model.sv]
// servo reference shaping filters: host issuing forward pulse bursts, counting smoothed pulses
// assumes its inputs change just after the rising edge of sys_clk
`timescale 1ns/1ps
module ssf_host_model (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic        [7:0]  burst_len,
  input  wire logic               burst_go,
  input  wire logic               pulse_out,
  input  wire logic               pulse_out_dir,
  output logic                    pulse_in,
  output logic                    pulse_in_dir,
  output logic signed      [15:0] out_count
);
  logic [7:0] left;
  // one pulse per cycle at most, forward direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left <= 8'h00;
      pulse_in <= 1'b0;
      pulse_in_dir <= 1'b1;
      out_count <= 16'sh0000;
    end else begin
      left <= burst_go ? burst_len : (left != 8'h00 ? left - 8'h01 : 8'h00);
      pulse_in <= left != 8'h00;
      if (pulse_out) out_count <= out_count + (pulse_out_dir ? 16'sh0001 : -16'sh0001);
    end
  end
endmodule

// [ssf_notch_stage.sv]
// servo reference shaping filters: one state-variable notch stage
// assumes din is steady around each tick and settings are already clamped
`timescale 1ns/1ps
module ssf_notch_stage
  import ssf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  ssf_stage_if.stage sif
);
  localparam logic [31:0] W_RST = (32'(RST_FREQ) * W_NUM) / W_DEN;
  localparam logic [31:0] D_RST = Q_ONE_Q16 / 32'(RST_QUAL);

  logic        [31:0] w_coef;
  logic        [31:0] d_coef;
  logic signed [31:0] bp;
  logic signed [31:0] lp;
  logic signed [15:0] dout_r;

  // coefficients only move when a setting is written
  wire [31:0] next_w = ssf_udiv(32'(sif.freq) * W_NUM, W_DEN);
  wire [31:0] next_d = ssf_udiv(Q_ONE_Q16, 32'(sif.quality));

  wire signed [31:0] x_s   = 32'(sif.din) <<< 8;
  wire signed [63:0] d_bp  = 64'(bp) * $signed({1'b0, d_coef});
  wire signed [31:0] hp    = x_s - lp - 32'(d_bp >>> 16);
  wire signed [63:0] w_hp  = 64'(hp) * $signed({1'b0, w_coef});
  wire signed [31:0] bp_n  = bp + 32'(w_hp >>> 16);
  wire signed [63:0] w_bp  = 64'(bp_n) * $signed({1'b0, w_coef});
  wire signed [31:0] lp_n  = lp + 32'(w_bp >>> 16);
  wire signed [31:0] notch = (hp + lp_n) >>> 8;
  wire signed [15:0] sat   = (notch > 32'sh0000_7FFF) ? 16'sh7FFF :
                             (notch < -32'sh0000_8000) ? -16'sh8000 : notch[15:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_coef <= W_RST;
      d_coef <= D_RST;
    end else if (sif.wr_coef) begin
      w_coef <= next_w;
      d_coef <= next_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bp     <= 32'sh0000_0000;
      lp     <= 32'sh0000_0000;
      dout_r <= 16'sh0000;
    end else if (!sif.en) begin
      bp     <= 32'sh0000_0000;
      lp     <= 32'sh0000_0000;
      dout_r <= sif.din;
    end else if (sif.tick) begin
      bp     <= bp_n;
      lp     <= lp_n;
      dout_r <= sat;
    end
  end

  assign sif.dout = dout_r;
endmodule

// [ssf_pkg.sv]
// servo reference shaping filters: shared constants, register map and helpers
// assumes a single 250 mhz clock; filter samples run on a 0.01 ms tick
package ssf_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_NS  = 10000;   // 0.01 ms sample period
  localparam int MS_TIME_NS    = 1000000;
  localparam int CYC_PER_TICK  = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_MS    = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W    = 12;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(CYC_PER_TICK - 1);

  // register byte offsets
  localparam logic [7:0] OFS_ACCEL    = 8'h00;
  localparam logic [7:0] OFS_DECEL    = 8'h04;
  localparam logic [7:0] OFS_POS_SEL  = 8'h08;
  localparam logic [7:0] OFS_POS_TC   = 8'h0C;
  localparam logic [7:0] OFS_POS_WIN  = 8'h10;
  localparam logic [7:0] OFS_TRQ_TC   = 8'h14;
  localparam logic [7:0] OFS_NOTCH_EN = 8'h18;
  localparam logic [7:0] OFS_N1_FREQ  = 8'h1C;
  localparam logic [7:0] OFS_N1_Q     = 8'h20;
  localparam logic [7:0] OFS_N2_FREQ  = 8'h24;
  localparam logic [7:0] OFS_N2_Q     = 8'h28;
  localparam logic [7:0] OFS_SPD_OUT  = 8'h2C;
  localparam logic [7:0] OFS_TRQ_OUT  = 8'h30;
  localparam logic [7:0] OFS_PEND     = 8'h34;

  // fields
  localparam int NOTCH1_EN_BIT = 0;
  localparam int NOTCH2_EN_BIT = 2;

  // ranges and reset values
  localparam logic [31:0] RAMP_MS_MAX  = 32'h0000_2710;  // 10000
  localparam logic [31:0] POS_TC_MAX   = 32'h0000_1900;  // 6400
  localparam logic [31:0] TRQ_TC_MAX   = 32'h0000_FFFF;
  localparam logic [31:0] FREQ_MIN     = 32'h0000_0032;  // 50
  localparam logic [31:0] FREQ_MAX     = 32'h0000_07D0;  // 2000
  localparam logic [31:0] QUAL_MIN     = 32'h0000_0032;  // 50
  localparam logic [31:0] QUAL_MAX     = 32'h0000_0190;  // 400
  localparam logic [15:0] RST_RAMP_MS  = 16'h0000;
  localparam logic [12:0] RST_POS_TC   = 13'h0000;
  localparam logic [15:0] RST_TRQ_TC   = 16'h0064;       // 100
  localparam logic [15:0] RST_FREQ     = 16'h07D0;       // 2000
  localparam logic [15:0] RST_QUAL     = 16'h0046;       // 70
  localparam logic        POS_SEL_RAMP = 1'b0;

  // arithmetic scaling
  localparam logic [31:0] ONE_Q16      = 32'h0001_0000;
  localparam logic [31:0] Q_ONE_Q16    = 32'h0064_0000;  // 100 * 2^16, q is in 0.01
  localparam logic [31:0] W_NUM        = 32'h0000_1015;  // 2*pi*2^16/fs, times 1000
  localparam logic [31:0] W_DEN        = 32'h0000_03E8;  // 1000
  localparam logic signed [15:0] SPEED_FULL = 16'sh7FFF;
  localparam int SLOT_N = 16;
  localparam int SLOT_SH = 4;

  function automatic logic [31:0] ssf_udiv(input logic [31:0] num, input logic [31:0] den);
    logic [31:0] q;
    logic [32:0] r;
    q = 32'h0000_0000;
    r = 33'h0_0000_0000;
    for (int i = 31; i >= 0; i--) begin
      r = {r[31:0], num[i]};
      if (den != 32'h0000_0000 && r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        q[i] = 1'b1;
      end
    end
    return (den == 32'h0000_0000) ? 32'h0000_0000 : q;
  endfunction

  function automatic logic [31:0] ssf_clamp(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// [ssf_properties.sv]
// servo reference shaping filters: port checker for ssf_top
// assumes one clock sys_clk and async active-high rst
`timescale 1ns/1ps
module ssf_properties
  import ssf_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic        [7:0]  paddr,
  input wire logic        [31:0] pwdata,
  input wire logic        [31:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic signed [15:0] speed_ref_in,
  input wire logic signed [15:0] speed_ref_out,
  input wire logic               pulse_in,
  input wire logic               pulse_in_dir,
  input wire logic               pulse_out,
  input wire logic               pulse_out_dir,
  input wire logic signed [15:0] torque_ref_in,
  input wire logic signed [15:0] torque_ref_out
);
  logic               wr, acc_z, dec_z, sel1, ptc_z, ttc_z, nen_z, pos_fast, trq_fast;
  logic signed [15:0] net_cnt, next_net;
  assign wr = psel && penable && pwrite && pready;
  assign pos_fast = !sel1 && ptc_z;
  assign trq_fast = ttc_z && nen_z;
  assign next_net = net_cnt + (pulse_in ? (pulse_in_dir ? 16'sh0001 : -16'sh0001) : 16'sh0000)
                    - (pulse_out ? (pulse_out_dir ? 16'sh0001 : -16'sh0001) : 16'sh0000);
  // track which settings are zero from the bus writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {acc_z, dec_z, sel1, ptc_z, ttc_z, nen_z} <= 6'b110101;
      net_cnt <= 16'sh0000;
    end else begin
      net_cnt <= next_net;
      if (wr && paddr == OFS_ACCEL) acc_z <= pwdata == 32'h0000_0000;
      if (wr && paddr == OFS_DECEL) dec_z <= pwdata == 32'h0000_0000;
      if (wr && paddr == OFS_POS_SEL) sel1 <= pwdata[0];
      if (wr && paddr == OFS_POS_TC) ptc_z <= pwdata == 32'h0000_0000;
      if (wr && paddr == OFS_TRQ_TC) ttc_z <= pwdata == 32'h0000_0000;
      if (wr && paddr == OFS_NOTCH_EN) nen_z <= !pwdata[NOTCH1_EN_BIT] && !pwdata[NOTCH2_EN_BIT];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_setup_unm;
    psel && !penable && paddr > OFS_PEND;
  endsequence
  sequence s_access_rd;
    psel && penable && !pwrite;
  endsequence
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_unm_err; psel && penable && paddr > OFS_PEND |-> pslverr; endproperty
  a_unm_err: assert property (p_unm_err) else $error("no error on unmapped");
  property p_map_ok; psel && penable && paddr <= OFS_PEND && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_map_ok: assert property (p_map_ok) else $error("error on mapped register");
  property p_unm_rd; s_setup_unm ##1 s_access_rd |-> prdata == 32'h0000_0000; endproperty
  a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not zero");
  property p_spd_pass; acc_z && dec_z |=> speed_ref_out == $past(speed_ref_in); endproperty
  a_spd_pass: assert property (p_spd_pass) else $error("speed not passed through");
  property p_pulse_pass; pos_fast && pulse_in && pulse_in_dir && net_cnt >= 16'sh0000
    |-> ##2 pulse_out && pulse_out_dir; endproperty
  a_pulse_pass: assert property (p_pulse_pass) else $error("pulse not passed");
  property p_drain; pos_fast && !pulse_in [*4] |-> net_cnt == 16'sh0000; endproperty
  a_drain: assert property (p_drain) else $error("pulse count not kept");
  property p_trq_pass; trq_fast [*4] |-> torque_ref_out == $past(torque_ref_in, 3); endproperty
  a_trq_pass: assert property (p_trq_pass) else $error("torque chain wrong");
endmodule
bind ssf_top ssf_properties #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_props (.sys_clk(sys_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_ref_in(speed_ref_in),
  .speed_ref_out(speed_ref_out), .pulse_in(pulse_in), .pulse_in_dir(pulse_in_dir),
  .pulse_out(pulse_out), .pulse_out_dir(pulse_out_dir), .torque_ref_in(torque_ref_in),
  .torque_ref_out(torque_ref_out));

// [ssf_stage_if.sv]
// servo reference shaping filters: link from the controller to one notch stage
// assumes both ends share the controller's clock and reset
`timescale 1ns/1ps
interface ssf_stage_if;
  logic               tick;
  logic               en;
  logic               wr_coef;
  logic        [15:0] freq;
  logic        [15:0] quality;
  logic signed [15:0] din;
  logic signed [15:0] dout;
  modport stage (input tick, en, wr_coef, freq, quality, din, output dout);
  modport ctrl  (output tick, en, wr_coef, freq, quality, din, input dout);
endinterface

// [ssf_top.sv]
// servo reference shaping filters: apb registers, speed soft start,
// position pulse smoothing, torque low-pass and two notch stages
// assumes all inputs are synchronous to sys_clk; pulse_in is one cycle wide
`timescale 1ns/1ps
module ssf_top
  import ssf_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic        [7:0]  paddr,
  input  wire logic        [31:0] pwdata,
  output logic             [31:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] speed_ref_in,
  output logic signed      [15:0] speed_ref_out,
  input  wire logic               pulse_in,
  input  wire logic               pulse_in_dir,
  output logic                    pulse_out,
  output logic                    pulse_out_dir,
  input  wire logic signed [15:0] torque_ref_in,
  output logic signed      [15:0] torque_ref_out
);
  // ---------------- registers ----------------
  logic [15:0] soft_start_accel_time;
  logic [15:0] soft_start_decel_time;
  logic        pos_ref_filter_select;
  logic [12:0] pos_ref_ramp_time_constant;
  logic [12:0] pos_ref_average_window;
  logic [15:0] torque_ref_lowpass_constant;
  logic        notch1_enable;
  logic        notch2_enable;
  logic [15:0] notch1_center_freq;
  logic [15:0] notch1_quality;
  logic [15:0] notch2_center_freq;
  logic [15:0] notch2_quality;
  logic signed [31:0] pending;

  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire wr_accel = wr_en & hit(paddr, OFS_ACCEL);
  wire wr_decel = wr_en & hit(paddr, OFS_DECEL);
  wire wr_sel   = wr_en & hit(paddr, OFS_POS_SEL);
  wire wr_ptc   = wr_en & hit(paddr, OFS_POS_TC);
  wire wr_pwin  = wr_en & hit(paddr, OFS_POS_WIN);
  wire wr_ttc   = wr_en & hit(paddr, OFS_TRQ_TC);
  wire wr_nen   = wr_en & hit(paddr, OFS_NOTCH_EN);
  wire wr_n1f   = wr_en & hit(paddr, OFS_N1_FREQ);
  wire wr_n1q   = wr_en & hit(paddr, OFS_N1_Q);
  wire wr_n2f   = wr_en & hit(paddr, OFS_N2_FREQ);
  wire wr_n2q   = wr_en & hit(paddr, OFS_N2_Q);

  wire mapped = hit(paddr, OFS_ACCEL) | hit(paddr, OFS_DECEL) | hit(paddr, OFS_POS_SEL) |
                hit(paddr, OFS_POS_TC) | hit(paddr, OFS_POS_WIN) | hit(paddr, OFS_TRQ_TC) |
                hit(paddr, OFS_NOTCH_EN) | hit(paddr, OFS_N1_FREQ) | hit(paddr, OFS_N1_Q) |
                hit(paddr, OFS_N2_FREQ) | hit(paddr, OFS_N2_Q) | hit(paddr, OFS_SPD_OUT) |
                hit(paddr, OFS_TRQ_OUT) | hit(paddr, OFS_PEND);

  // written values are clamped into their legal range
  wire [31:0] cl_ramp = ssf_clamp(pwdata, 32'h0000_0000, RAMP_MS_MAX);
  wire [31:0] cl_ptc  = ssf_clamp(pwdata, 32'h0000_0000, POS_TC_MAX);
  wire [31:0] cl_ttc  = ssf_clamp(pwdata, 32'h0000_0000, TRQ_TC_MAX);
  wire [31:0] cl_freq = ssf_clamp(pwdata, FREQ_MIN, FREQ_MAX);
  wire [31:0] cl_qual = ssf_clamp(pwdata, QUAL_MIN, QUAL_MAX);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      soft_start_accel_time       <= RST_RAMP_MS;
      soft_start_decel_time       <= RST_RAMP_MS;
      pos_ref_filter_select       <= POS_SEL_RAMP;
      pos_ref_ramp_time_constant  <= RST_POS_TC;
      pos_ref_average_window      <= RST_POS_TC;
      torque_ref_lowpass_constant <= RST_TRQ_TC;
      notch1_enable               <= 1'b0;
      notch2_enable               <= 1'b0;
      notch1_center_freq          <= RST_FREQ;
      notch1_quality              <= RST_QUAL;
      notch2_center_freq          <= RST_FREQ;
      notch2_quality              <= RST_QUAL;
    end else begin
      if (wr_accel) soft_start_accel_time <= cl_ramp[15:0];
      if (wr_decel) soft_start_decel_time <= cl_ramp[15:0];
      if (wr_sel) pos_ref_filter_select <= pwdata[0];
      if (wr_ptc) pos_ref_ramp_time_constant <= cl_ptc[12:0];
      if (wr_pwin) pos_ref_average_window <= cl_ptc[12:0];
      if (wr_ttc) torque_ref_lowpass_constant <= cl_ttc[15:0];
      if (wr_nen) notch1_enable <= pwdata[NOTCH1_EN_BIT];
      if (wr_nen) notch2_enable <= pwdata[NOTCH2_EN_BIT];
      if (wr_n1f) notch1_center_freq <= cl_freq[15:0];
      if (wr_n1q) notch1_quality <= cl_qual[15:0];
      if (wr_n2f) notch2_center_freq <= cl_freq[15:0];
      if (wr_n2q) notch2_quality <= cl_qual[15:0];
    end
  end

  // read data is captured in the setup cycle, so the access phase needs no wait
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      OFS_ACCEL:    rd_mux = 32'(soft_start_accel_time);
      OFS_DECEL:    rd_mux = 32'(soft_start_decel_time);
      OFS_POS_SEL:  rd_mux = 32'(pos_ref_filter_select);
      OFS_POS_TC:   rd_mux = 32'(pos_ref_ramp_time_constant);
      OFS_POS_WIN:  rd_mux = 32'(pos_ref_average_window);
      OFS_TRQ_TC:   rd_mux = 32'(torque_ref_lowpass_constant);
      OFS_NOTCH_EN: rd_mux = (32'(notch1_enable) << NOTCH1_EN_BIT) |
                             (32'(notch2_enable) << NOTCH2_EN_BIT);
      OFS_N1_FREQ:  rd_mux = 32'(notch1_center_freq);
      OFS_N1_Q:     rd_mux = 32'(notch1_quality);
      OFS_N2_FREQ:  rd_mux = 32'(notch2_center_freq);
      OFS_N2_Q:     rd_mux = 32'(notch2_quality);
      OFS_SPD_OUT:  rd_mux = 32'(speed_ref_out);
      OFS_TRQ_OUT:  rd_mux = 32'(torque_ref_out);
      OFS_PEND:     rd_mux = pending;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= rd_mux;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------- sample tick ----------------
  logic [TICK_CNT_W-1:0] tick_cnt;
  wire tick = (tick_cnt == TICK_LAST);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tick_cnt <= '0;
    else tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  // ---------------- speed soft start ----------------
  logic [31:0] spd_acc;
  wire signed [15:0] spd_tgt = speed_ref_in;
  wire [15:0] mag_tgt = spd_tgt[15] ? 16'(-spd_tgt) : spd_tgt;
  wire [15:0] mag_out = speed_ref_out[15] ? 16'(-speed_ref_out) : speed_ref_out;
  wire speeding_up = (speed_ref_out == 16'sh0000) ||
                     ((speed_ref_out[15] == spd_tgt[15]) && (mag_tgt > mag_out));
  wire [15:0] ramp_ms = speeding_up ? soft_start_accel_time
                                    : soft_start_decel_time;
  wire [31:0] ramp_cyc = 32'(ramp_ms) * 32'(CYC_PER_MS_P);
  wire [31:0] spd_sum  = spd_acc + 32'(SPEED_FULL);
  wire no_ramp = (soft_start_accel_time == RST_RAMP_MS) &&
                 (soft_start_decel_time == RST_RAMP_MS);
  wire signed [15:0] spd_step = (spd_tgt > speed_ref_out) ? 16'sh0001 : -16'sh0001;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      speed_ref_out <= 16'sh0000;
      spd_acc       <= 32'h0000_0000;
    end else if (no_ramp || ramp_ms == RST_RAMP_MS) begin
      speed_ref_out <= spd_tgt;
      spd_acc       <= 32'h0000_0000;
    end else if (speed_ref_out == spd_tgt) begin
      spd_acc <= 32'h0000_0000;
    end else if (spd_sum >= ramp_cyc) begin
      speed_ref_out <= speed_ref_out + spd_step;
      spd_acc       <= spd_sum - ramp_cyc;
    end else begin
      spd_acc <= spd_sum;
    end
  end

  // ---------------- position pulse smoothing ----------------
  logic [31:0] pos_acc;
  logic [15:0] slot [SLOT_N];
  logic [15:0] cur_cnt;
  logic [31:0] slot_cnt;
  logic [31:0] win_sum;

  always_comb begin
    win_sum = 32'h0000_0000;
    for (int i = 0; i < SLOT_N; i++) win_sum = win_sum + 32'(slot[i]);
  end

  wire [31:0] mag_pend = pending[31] ? 32'(-pending) : 32'(pending);
  wire        have     = (pending != 32'sh0000_0000);
  wire [31:0] ptc_cyc  = 32'(pos_ref_ramp_time_constant) * 32'(CYC_PER_TICK);
  wire [31:0] win_cyc  = 32'(pos_ref_average_window) * 32'(CYC_PER_TICK);
  wire [31:0] slot_len = win_cyc >> SLOT_SH;
  wire        mode_avg = pos_ref_filter_select;
  wire [31:0] pos_thr  = mode_avg ? win_cyc : ptc_cyc;
  wire [31:0] pos_add  = mode_avg ? win_sum : mag_pend;
  wire [31:0] pos_sum  = pos_acc + pos_add;
  wire drain = mode_avg && (win_sum == 32'h0000_0000) && (cur_cnt == 16'h0000);
  wire emit  = have && ((pos_thr == 32'h0000_0000) || drain || (pos_sum >= pos_thr));
  wire slot_end = (slot_cnt + 32'h0000_0001 >= slot_len);

  wire signed [31:0] in_delta  = !pulse_in ? 32'sh0000_0000 :
                                 (pulse_in_dir ? 32'sh0000_0001 : -32'sh0000_0001);
  wire signed [31:0] out_delta = !emit ? 32'sh0000_0000 :
                                 (pending[31] ? -32'sh0000_0001 : 32'sh0000_0001);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending       <= 32'sh0000_0000;
      pos_acc       <= 32'h0000_0000;
      pulse_out     <= 1'b0;
      pulse_out_dir <= 1'b0;
    end else begin
      pending   <= pending + in_delta - out_delta;
      pulse_out <= emit;
      if (emit) pulse_out_dir <= ~pending[31];
      if (wr_sel || !have) pos_acc <= 32'h0000_0000;
      else if (emit && pos_thr != 32'h0000_0000 && !drain) pos_acc <= pos_sum - pos_thr;
      else if (!emit) pos_acc <= pos_sum;
    end
  end

  // window history: pulses seen per slot, oldest falls off the end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOT_N; i++) slot[i] <= 16'h0000;
      cur_cnt  <= 16'h0000;
      slot_cnt <= 32'h0000_0000;
    end else if (slot_end) begin
      slot[0]  <= cur_cnt + 16'(pulse_in);
      for (int i = 1; i < SLOT_N; i++) slot[i] <= slot[i-1];
      cur_cnt  <= 16'h0000;
      slot_cnt <= 32'h0000_0000;
    end else begin
      cur_cnt  <= cur_cnt + 16'(pulse_in);
      slot_cnt <= slot_cnt + 32'h0000_0001;
    end
  end

  // ---------------- torque low-pass ----------------
  logic [31:0] trq_k;
  logic signed [31:0] trq_y;
  logic signed [15:0] trq_lp;
  wire [31:0] next_k = ssf_udiv(ONE_Q16, 32'(cl_ttc[15:0]));
  wire signed [31:0] trq_x = 32'(torque_ref_in) <<< 16;
  wire signed [63:0] trq_d = 64'(trq_x - trq_y) * $signed({1'b0, trq_k});
  wire signed [31:0] next_y = trq_y + 32'(trq_d >>> 16);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) trq_k <= ONE_Q16 / 32'(RST_TRQ_TC);
    else if (wr_ttc) trq_k <= next_k;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trq_y  <= 32'sh0000_0000;
      trq_lp <= 16'sh0000;
    end else if (torque_ref_lowpass_constant == 16'h0000) begin
      trq_y  <= trq_x;
      trq_lp <= torque_ref_in;
    end else if (tick) begin
      trq_y  <= next_y;
      trq_lp <= next_y[31:16];
    end
  end

  // ---------------- notch chain ----------------
  ssf_stage_if n1_if ();
  ssf_stage_if n2_if ();

  assign n1_if.tick    = tick;
  assign n1_if.en      = notch1_enable;
  assign n1_if.wr_coef = wr_n1f | wr_n1q;
  assign n1_if.freq    = notch1_center_freq;
  assign n1_if.quality = notch1_quality;
  assign n1_if.din     = trq_lp;
  assign n2_if.tick    = tick;
  assign n2_if.en      = notch2_enable;
  assign n2_if.wr_coef = wr_n2f | wr_n2q;
  assign n2_if.freq    = notch2_center_freq;
  assign n2_if.quality = notch2_quality;
  assign n2_if.din     = n1_if.dout;

  // the same stage module serves both positions
  ssf_notch_stage u_notch1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sif     (n1_if.stage)
  );

  ssf_notch_stage u_notch2 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sif     (n2_if.stage)
  );

  assign torque_ref_out = n2_if.dout;
endmodule

// [ssf_top_bench.sv]
// servo reference shaping filters: self-checking bench over apb and reference ports
// assumes ssf_top, ssf_host_model and the bound checker are compiled before it
`timescale 1ns/1ps
module ssf_top_bench
  import ssf_pkg::*;
;
  logic               sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, go;
  logic               pin, pdir, pout, podir;
  logic        [7:0]  paddr, blen;
  logic        [31:0] pwdata, prdata, rd;
  logic signed [15:0] spd_in, spd_out, trq_in, trq_out, pcnt, ex;
  int                 failures, n_tests, n;
  logic [7:0]  ofs [11] = '{OFS_ACCEL, OFS_DECEL, OFS_POS_TC, OFS_POS_WIN, OFS_N1_FREQ,
    OFS_N1_Q, OFS_N2_FREQ, OFS_N2_Q, OFS_TRQ_TC, OFS_POS_SEL, OFS_NOTCH_EN};
  logic [31:0] wv [11] = '{32'h0000_4E20, 32'h0000_4E20, 32'h0000_1B58, 32'h0000_1B58,
    32'h0000_000A, 32'h0000_01F4, 32'h0000_0BB8, 32'h0000_0001, 32'h0001_0000, 32'h0, 32'h5};
  logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_07D0, 32'h0000_0046,
    32'h0000_07D0, 32'h0000_0046, 32'h0000_0064, 32'h0, 32'h0};
  logic [31:0] cv [11] = '{32'h0000_2710, 32'h0000_2710, 32'h0000_1900, 32'h0000_1900,
    32'h0000_0032, 32'h0000_0190, 32'h0000_07D0, 32'h0000_0032, 32'h0000_FFFF, 32'h0, 32'h5};
  ssf_top #(.CYC_PER_MS_P(100)) DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speed_ref_in(spd_in), .speed_ref_out(spd_out),
    .pulse_in(pin), .pulse_in_dir(pdir), .pulse_out(pout), .pulse_out_dir(podir),
    .torque_ref_in(trq_in), .torque_ref_out(trq_out));
  ssf_host_model host (.sys_clk(sys_clk), .rst(rst), .burst_len(blen), .burst_go(go),
    .pulse_out(pout), .pulse_out_dir(podir), .pulse_in(pin), .pulse_in_dir(pdir),
    .out_count(pcnt));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    chk({31'h0, k < 100}, 32'h1, "apb answer");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    test_done;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, go, blen} = {4'b1000, 8'h00, 32'h0, 1'b0, 8'h00};
    {spd_in, trq_in, failures, n_tests} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i], "reset value");
      apb(1'b1, ofs[i], wv[i]);
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, cv[i], "clamped value");
    end
    for (int i = 0; i < 11; i++) apb(1'b1, ofs[i], (i < 4 || i > 7) ? 32'h0 : rv[i]);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    apb(1'b1, OFS_PEND, 32'h0000_0005);
    apb(1'b0, OFS_PEND, 32'h0);
    chk({err, rd[30:0]}, 32'h0, "read-only pending");
    $display("test registers done");
    spd_in <= 16'sh04D2;
    repeat (3) @(posedge sys_clk);
    chk({16'h0, spd_out}, 32'h0000_04D2, "speed pass");
    spd_in <= 16'sh0000;
    apb(1'b1, OFS_ACCEL, 32'h0000_0001);
    spd_in <= 16'sh03E8;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, spd_out > 16'sh0000 && spd_out < 16'sh03E8}, 32'h1, "speed ramping");
    for (n = 0; spd_out !== 16'sh03E8 && n < 20000; n++) @(posedge sys_clk);
    chk({16'h0, spd_out}, 32'h0000_03E8, "speed reached");
    spd_in <= 16'sh0000;
    repeat (2) @(posedge sys_clk);
    chk({16'h0, spd_out}, 32'h0, "zero decel jumps");
    apb(1'b1, OFS_ACCEL, 32'h0);
    $display("test speed done");
    trq_in <= 16'shFE0C;
    repeat (6) @(posedge sys_clk);
    chk({16'h0, trq_out}, 32'h0000_FE0C, "torque pass");
    apb(1'b1, OFS_NOTCH_EN, 32'h0000_0001);
    trq_in <= 16'sh0100;
    repeat (6) @(posedge sys_clk);
    chk({31'h0, trq_out !== 16'sh0100}, 32'h1, "notch applied");
    $display("test torque done");
    {blen, go} <= {8'h14, 1'b1};
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk({16'h0, pcnt}, 32'h0000_0014, "fast pulse count");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, OFS_POS_SEL, 32'(m));
      apb(1'b1, m ? OFS_POS_WIN : OFS_POS_TC, 32'h0000_0002);
      ex = 16'sh0024 + 16'sh0010 * 16'(m);
      {blen, go} <= {8'h10, 1'b1};
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk({16'h0, pcnt}, {16'h0, ex - 16'sh0010}, "pulses smoothed");
      for (n = 0; pcnt !== ex && n < 20000; n++) @(posedge sys_clk);
      chk({16'h0, pcnt}, {16'h0, ex}, "smoothed pulse count");
    end
    $display("test pulses done");
    test_done;
  end
endmodule
